// [verilog/wxf_map.vh]
// register map, field positions, reset values and fault action codes for wxf
// assumes apb byte addresses, one 32-bit word per register
`ifndef WXF_MAP_VH
`define WXF_MAP_VH
`define WXF_ADDR_CTRL     8'h00
`define WXF_ADDR_FDMASK   8'h08
`define WXF_ADDR_FDCTRL   8'h0C
`define WXF_ADDR_STATUS   8'h10
`define WXF_ADDR_DTBOTH   8'h18
`define WXF_ADDR_DTLSBUF  8'h20
`define WXF_ADDR_DTHSBUF  8'h24
`define WXF_ADDR_OVRBUF   8'h28
`define WXF_ADDR_LOCK     8'h2C
`define WXF_ADDR_PINS     8'h30
`define WXF_CTRL_PGM      5
`define WXF_CTRL_CWCM     4
`define WXF_FD_RESTART    2
`define WXF_FD_ACT_LO     0
`define WXF_ST_FAULT      2
`define WXF_ST_HSV        1
`define WXF_ST_LSV        0
`define WXF_ACT_NONE      2'b00
`define WXF_ACT_CLEARDIR  2'b11
`define WXF_RST_BYTE      8'h00
`define WXF_FAULT_LAT     2
`endif

// [verilog/wxf_dtgen.v]
// one dead-time generator: edge detect, reload and down counter
// assumes the waveform input is on the same clock as this module
`timescale 1ns/10ps
module wxf_dtgen #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             clk,
  input  wire             rst,
  // waveform and dead-time settings
  input  wire             wave,
  input  wire [WIDTH-1:0] low_side_dead_time,
  input  wire [WIDTH-1:0] high_side_dead_time,
  // complementary outputs
  output reg              low_side_output,
  output reg              high_side_output
);

  reg             wave_q;
  reg [WIDTH-1:0] cnt_q;
  reg [WIDTH-1:0] cnt_d;
  wire            rise = wave & ~wave_q;
  wire            fall = ~wave & wave_q;

  always @* begin
    cnt_d = cnt_q;
    if (rise) begin
      cnt_d = low_side_dead_time;
    end else if (fall) begin
      cnt_d = high_side_dead_time;
    end else if (cnt_q != {WIDTH{1'b0}}) begin
      cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      wave_q           <= 1'b0;
      cnt_q            <= {WIDTH{1'b0}};
      low_side_output  <= 1'b0;
      high_side_output <= 1'b0;
    end else begin
      wave_q <= wave;
      cnt_q  <= cnt_d;
      // both sides off while counting, so with nonzero dead time they never switch together
      low_side_output  <= wave & (cnt_d == {WIDTH{1'b0}});
      high_side_output <= ~wave & (cnt_d == {WIDTH{1'b0}});
    end
  end

endmodule

// [verilog/wxf_top.v]
// waveform extension: dead time, pattern generation, fault protection
// assumes waveforms and update come from the timer on CLK_SYS; fault
// events arrive asynchronously and are synchronised here
//
// Summary of operation
// - dead-time enable takes pin pair over
// - override enables replace channel output enables
// - each waveform split into complementary pair
// - dead time keeps both sides low
// - four identical generators, shared setting
// - separate double-buffered low and high values
// - counter decrements each cycle, stops at zero
// - nonzero counter forces both outputs off
// - rise loads low value, fall loads high
// - pattern mode bypasses dead time, reuses storage
// - pattern mode muxes channel A onto pins
// - buffers move to active only on update
// - selected event channels ORed into fault
// - clear-direction action tri-states channel pins
// - fault sets flag and timer error flag
// - fault acts within two clock cycles; pins react three cycles after event (two sync flops, registered clear)
// - latched restore needs inactive fault, cleared flag
// - cycle restore needs only inactive fault
// - leaving fault restores channel direction bits
// - override register writes blocked during fault
// - lock bit blocks control, override, mask writes
// - action code 00 none, 11 clear direction
// - restart bit zero latched, one cycle
// - fault flag cleared by writing one
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "wxf_map.vh"
module wxf_top #(
  parameter NCH   = 4,
  parameter DTW   = 8,
  parameter NEV   = 8,
  parameter NPIN  = 8
) (
  // clock and reset
  input  wire            CLK_SYS,
  input  wire            RST,
  // apb slave
  input  wire            PSEL,
  input  wire            PENABLE,
  input  wire            PWRITE,
  input  wire [7:0]      PADDR,
  input  wire [31:0]     PWDATA,
  output reg  [31:0]     PRDATA,
  output reg             PREADY,
  output reg             PSLVERR,
  // timer side
  input  wire [NCH-1:0]  WAVEFORM_GENERATOR_OUTPUT,
  input  wire [NCH-1:0]  CHANNEL_OUTPUT_ENABLES,
  input  wire            UPDATE,
  input  wire [NEV-1:0]  FAULT_EVENTS,
  output reg             TIMER_ERROR_FLAG_SET,
  // port side
  output reg  [NPIN-1:0] PORT_OUT,
  output reg  [NPIN-1:0] PORT_OVERRIDE,
  output reg  [NPIN-1:0] PORT_DIR_CLEAR
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [5:0]      ctrl_q;
  reg  [NEV-1:0]  fdmask_q;
  reg  [2:0]      fdctrl_q;
  reg             fault_flag_q;
  reg             lock_q;
  reg  [DTW-1:0]  low_side_dead_time_q;
  reg  [DTW-1:0]  high_side_dead_time_q;
  reg  [DTW-1:0]  dtlsbuf_q;
  reg  [DTW-1:0]  dthsbuf_q;
  reg             lsv_q;
  reg             hsv_q;
  reg  [NPIN-1:0] ovr_q;
  reg  [NPIN-1:0] ovrbuf_q;
  reg             ovrv_q;
  reg  [NEV-1:0]  ev_s1_q;
  reg  [NEV-1:0]  ev_s2_q;
  reg             in_fault_q;

  wire            wr = PSEL & PENABLE & PWRITE;
  wire            pgm = ctrl_q[`WXF_CTRL_PGM];
  wire            cwcm = ctrl_q[`WXF_CTRL_CWCM];
  wire [NCH-1:0]  dt_en = ctrl_q[NCH-1:0];
  wire [1:0]      fd_act = fdctrl_q[`WXF_FD_ACT_LO+1:`WXF_FD_ACT_LO];
  wire            fd_cyc = fdctrl_q[`WXF_FD_RESTART];
  wire            fd_on = (fd_act == `WXF_ACT_CLEARDIR);
  wire            ev_any = |(ev_s2_q & fdmask_q);
  wire            flag_clr = wr & (PADDR == `WXF_ADDR_STATUS) &
                             PWDATA[`WXF_ST_FAULT];

  // ----------------------------------------------------------------
  // event synchroniser
  // ----------------------------------------------------------------
  // two flops cost the whole two-cycle budget; action is combinational
  // off the synced level so the pins follow on the next edge
  always @(posedge CLK_SYS) begin
    if (RST) begin
      ev_s1_q <= {NEV{1'b0}};
      ev_s2_q <= {NEV{1'b0}};
    end else begin
      ev_s1_q <= FAULT_EVENTS;
      ev_s2_q <= ev_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // apb register writes
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      ctrl_q    <= 6'h00;
      fdmask_q  <= {NEV{1'b0}};
      fdctrl_q  <= 3'h0;
      lock_q    <= 1'b0;
      dtlsbuf_q <= {DTW{1'b0}};
      dthsbuf_q <= {DTW{1'b0}};
      ovrbuf_q  <= {NPIN{1'b0}};
      ovrv_q    <= 1'b0;
      lsv_q     <= 1'b0;
      hsv_q     <= 1'b0;
    end else begin
      if (UPDATE) begin
        lsv_q  <= 1'b0;
        hsv_q  <= 1'b0;
        ovrv_q <= 1'b0;
      end
      if (wr) begin
        case (PADDR)
          `WXF_ADDR_CTRL: begin
            if (!lock_q) begin
              ctrl_q <= PWDATA[5:0];
            end
          end
          `WXF_ADDR_FDMASK: begin
            if (!lock_q) begin
              fdmask_q <= PWDATA[NEV-1:0];
            end
          end
          `WXF_ADDR_FDCTRL: begin
            fdctrl_q <= PWDATA[2:0];
          end
          `WXF_ADDR_LOCK: begin
            lock_q <= PWDATA[0];
          end
          `WXF_ADDR_DTLSBUF: begin
            dtlsbuf_q <= PWDATA[DTW-1:0];
            lsv_q     <= 1'b1;
          end
          `WXF_ADDR_DTHSBUF: begin
            dthsbuf_q <= PWDATA[DTW-1:0];
            hsv_q     <= 1'b1;
          end
          `WXF_ADDR_DTBOTH: begin
            dtlsbuf_q <= PWDATA[DTW-1:0];
            dthsbuf_q <= PWDATA[DTW-1:0];
            lsv_q     <= 1'b1;
            hsv_q     <= 1'b1;
          end
          `WXF_ADDR_OVRBUF: begin
            if (!lock_q && !in_fault_q) begin
              ovrbuf_q <= PWDATA[NPIN-1:0];
              ovrv_q   <= 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // active copies, loaded on update only
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS) begin
    if (RST) begin
      low_side_dead_time_q <= {DTW{1'b0}};
      high_side_dead_time_q <= {DTW{1'b0}};
      ovr_q  <= {NPIN{1'b0}};
    end else if (UPDATE) begin
      if (lsv_q) begin
        low_side_dead_time_q <= dtlsbuf_q;
      end
      if (hsv_q) begin
        high_side_dead_time_q <= dthsbuf_q;
      end
      if (ovrv_q) begin
        ovr_q <= ovrbuf_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // fault state
  // ----------------------------------------------------------------
  wire flag_next = (fault_flag_q & ~flag_clr) | (fd_on & ev_any);
  always @(posedge CLK_SYS) begin
    if (RST) begin
      fault_flag_q         <= 1'b0;
      in_fault_q           <= 1'b0;
      TIMER_ERROR_FLAG_SET <= 1'b0;
    end else begin
      // set wins over a same-cycle clear
      fault_flag_q <= flag_next;
      TIMER_ERROR_FLAG_SET <= fd_on & ev_any & ~fault_flag_q;
      if (fd_on & ev_any) begin
        in_fault_q <= 1'b1;
      end else if (in_fault_q && UPDATE) begin
        if (fd_cyc || !fault_flag_q) begin
          in_fault_q <= 1'b0;
        end
      end
      if (!fd_on) begin
        in_fault_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // dead-time generators
  // ----------------------------------------------------------------
  wire [NCH-1:0] ls;
  wire [NCH-1:0] hs;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : gen_dt
      wire wave_in = cwcm ? WAVEFORM_GENERATOR_OUTPUT[0] :
                            WAVEFORM_GENERATOR_OUTPUT[g];
      wxf_dtgen #(.WIDTH(DTW)) u_dt (
        .clk                 (CLK_SYS),
        .rst                 (RST),
        .wave                (wave_in),
        .low_side_dead_time  (low_side_dead_time_q),
        .high_side_dead_time (high_side_dead_time_q),
        .low_side_output     (ls[g]),
        .high_side_output    (hs[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // port mux
  // ----------------------------------------------------------------
  reg [NPIN-1:0] out_d;
  reg [NPIN-1:0] ovr_d;
  reg [NPIN-1:0] pair_en;
  reg [NPIN-1:0] drv_en;
  integer i;
  always @* begin
    out_d   = {NPIN{1'b0}};
    ovr_d   = {NPIN{1'b0}};
    pair_en = {NPIN{1'b0}};
    drv_en  = {NPIN{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      pair_en[2*i]   = dt_en[i];
      pair_en[2*i+1] = dt_en[i];
      drv_en[2*i]    = CHANNEL_OUTPUT_ENABLES[i];
      drv_en[2*i+1]  = CHANNEL_OUTPUT_ENABLES[i];
    end
    if (pgm) begin
      // pattern sits in the low-side store, channel a on override pins
      for (i = 0; i < NPIN; i = i + 1) begin
        out_d[i] = ovr_q[i] ? WAVEFORM_GENERATOR_OUTPUT[0] :
                              low_side_dead_time_q[i % DTW];
      end
      ovr_d = {NPIN{1'b1}};
    end else begin
      for (i = 0; i < NCH; i = i + 1) begin
        out_d[2*i]   = ls[i];
        out_d[2*i+1] = hs[i];
      end
      // override enables replace the timer's enables on owned pairs
      ovr_d = pair_en & ovr_q;
      ovr_d = ovr_d | (~pair_en & drv_en);
    end
  end

  always @(posedge CLK_SYS) begin
    if (RST) begin
      PORT_OUT       <= {NPIN{1'b0}};
      PORT_OVERRIDE  <= {NPIN{1'b0}};
      PORT_DIR_CLEAR <= {NPIN{1'b0}};
    end else begin
      PORT_OUT      <= out_d;
      PORT_OVERRIDE <= ovr_d;
      // dropping the clear hands direction back to the port
      if (fd_on & (ev_any | in_fault_q)) begin
        PORT_DIR_CLEAR <= pgm ? {NPIN{1'b1}} : pair_en;
      end else begin
        PORT_DIR_CLEAR <= {NPIN{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // apb read and response
  // ----------------------------------------------------------------
  reg [31:0] rd_d;
  reg        err_d;
  always @* begin
    rd_d  = 32'h0000_0000;
    err_d = 1'b0;
    case (PADDR)
      `WXF_ADDR_CTRL:    rd_d[5:0] = ctrl_q;
      `WXF_ADDR_FDMASK:  rd_d[NEV-1:0] = fdmask_q;
      `WXF_ADDR_FDCTRL:  rd_d[2:0] = fdctrl_q;
      `WXF_ADDR_STATUS:  rd_d[2:0] = {fault_flag_q, hsv_q, lsv_q};
      `WXF_ADDR_DTBOTH:  rd_d[DTW-1:0] = low_side_dead_time_q;
      `WXF_ADDR_DTLSBUF: rd_d[DTW-1:0] = dtlsbuf_q;
      `WXF_ADDR_DTHSBUF: rd_d[DTW-1:0] = dthsbuf_q;
      `WXF_ADDR_OVRBUF:  rd_d[NPIN-1:0] = ovr_q;
      `WXF_ADDR_LOCK:    rd_d[0] = lock_q;
      `WXF_ADDR_PINS:    rd_d[0] = in_fault_q;
      default:           err_d = 1'b1;
    endcase
  end

  // no wait state: pready rises at the edge that starts the first access cycle
  always @(posedge CLK_SYS) begin
    if (RST) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL & ~PENABLE;
      PRDATA  <= rd_d;
      PSLVERR <= PSEL & ~PENABLE & err_d;
    end
  end

endmodule

// [verif/wxf_props.sv]
// checker for wxf_top: apb answer, fault reaction, output overlap
// assumes bind into wxf_top, one clock, sync active-high reset
`timescale 1ns/10ps
module wxf_props #(
  parameter NEV  = 8,
  parameter NPIN = 8
) (
  // clock, reset, apb
  input wire            CLK_SYS,
  input wire            RST,
  input wire            PSEL,
  input wire            PENABLE,
  input wire [7:0]      PADDR,
  input wire            PREADY,
  input wire            PSLVERR,
  // timer and port
  input wire            UPDATE,
  input wire [NEV-1:0]  FAULT_EVENTS,
  input wire            TIMER_ERROR_FLAG_SET,
  input wire [NPIN-1:0] PORT_OUT,
  input wire [NPIN-1:0] PORT_OVERRIDE,
  input wire [NPIN-1:0] PORT_DIR_CLEAR
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  wire any_ev  = |FAULT_EVENTS;
  wire any_clr = |PORT_DIR_CLEAR;
  // pattern mode may drive both pins of a pair; the bench avoids it
  wire both_hi = |(PORT_OUT[7:1] & PORT_OUT[6:0] & PORT_OVERRIDE[7:1]
                   & PORT_OVERRIDE[6:0] & 7'h55);
  sequence apb_setup;
    PSEL && !PENABLE;
  endsequence
  sequence apb_done;
    PSEL && PENABLE && PREADY;
  endsequence
  sequence ev_seen;
    $past(any_ev, 2) || $past(any_ev, 3) || $past(any_ev, 4);
  endsequence
  ready_setup_a: assert property (apb_setup |=> apb_done)
    else $error("no pready after setup");
  ready_cause_a: assert property (PREADY |-> $past(PSEL && !PENABLE))
    else $error("pready without setup");
  unmapped_err_a: assert property (
    PREADY && $past(PADDR) == 8'h04 |-> PSLVERR)
    else $error("no pslverr on unmapped address");
  mapped_ok_a: assert property (
    PREADY && $past(PADDR) == 8'h00 |-> !PSLVERR)
    else $error("pslverr on mapped address");
  err_pulse_a:
    assert property (TIMER_ERROR_FLAG_SET |=> !TIMER_ERROR_FLAG_SET)
    else $error("error flag pulse too long");
  fault_quick_a:
    assert property ($rose(any_clr) |-> ev_seen)
    else $error("direction clear without recent event");
  fault_exit_a:
    assert property ($fell(any_clr) |-> $past(UPDATE) || $past(UPDATE, 2))
    else $error("fault left without update");
  no_overlap_a:
    assert property (!both_hi)
    else $error("both sides of a pair high");
endmodule
bind wxf_top wxf_props #(.NEV(NEV), .NPIN(NPIN)) wxf_props_inst (
  .CLK_SYS(CLK_SYS), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .UPDATE(UPDATE),
  .FAULT_EVENTS(FAULT_EVENTS),
  .TIMER_ERROR_FLAG_SET(TIMER_ERROR_FLAG_SET), .PORT_OUT(PORT_OUT),
  .PORT_OVERRIDE(PORT_OVERRIDE), .PORT_DIR_CLEAR(PORT_DIR_CLEAR));

// [verif/wxf_timer_model.sv]
// timer partner: free-running count, compare waveforms, update pulse
// assumes the same clock as wxf_top and a sync active-high reset
`timescale 1ns/10ps
module wxf_timer_model (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // waveforms and update
  output reg  [3:0] wave,
  output reg        upd
);
  // ----------------------------------------
  // timer
  // ----------------------------------------
  reg [4:0] cnt_q;
  integer   i;
  always @(posedge clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
      wave  <= 4'h0;
      upd   <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 5'h01;
      // one update per period, at the wrap, like the real timer
      upd   <= (cnt_q == 5'h1F);
      // duty differs per channel so each generator sees its own falling edge; all four rise together
      for (i = 0; i < 4; i = i + 1)
        wave[i] <= (cnt_q < 16 + i);
    end
  end
endmodule

// [verif/test_wxf_top.sv]
// self-checking bench for wxf_top with the timer partner model
// assumes wxf_top, wxf_props and wxf_timer_model compiled first
`timescale 1ns/10ps
module test_wxf_top;
  reg         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [7:0]  paddr = 8'h00, fev = 8'h00, dl, dh, cl, ch;
  reg  [31:0] pwdata = 32'h0000_0000;
  reg  [3:0]  coe = 4'h0;
  wire [31:0] prdata;
  wire        pready, pslverr, upd, tef;
  wire [3:0]  wave;
  wire [7:0]  pout, povr, pdc;
  reg  [31:0] exp_q[$];
  integer     error_cnt = 0, comparisons = 0, cyc = 0, seed = 32'ha6f3;
  integer     c, tef_n = 0;
  wxf_top wxf_top_inst (
    .CLK_SYS(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .WAVEFORM_GENERATOR_OUTPUT(wave),
    .CHANNEL_OUTPUT_ENABLES(coe), .UPDATE(upd), .FAULT_EVENTS(fev),
    .TIMER_ERROR_FLAG_SET(tef), .PORT_OUT(pout), .PORT_OVERRIDE(povr),
    .PORT_DIR_CLEAR(pdc));
  wxf_timer_model wxf_timer_model_inst (
    .clk(clk), .rst(rst), .wave(wave), .upd(upd));
  always #50 clk = ~clk;
  task test_done;
    begin
      if (error_cnt == 0 && comparisons > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // read data is judged where it is taken: at the access edge
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (tef === 1'b1)
      tef_n = tef_n + 1;
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk("prdata", exp_q.pop_front(), prdata);
    if (cyc == 10000) begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  end
  task apb(input w, input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      // request stands until pready is seen high at a rising edge
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      exp_q.push_back({24'h00_0000, e});
      apb(1'b0, a, 8'h00);
    end
  endtask
  task wu(input integer n);
    begin
      repeat (n) begin
        @(negedge clk);
        while (upd !== 1'b1)
          @(negedge clk);
      end
      repeat (4) @(posedge clk);
    end
  endtask
  // cycles from a waveform edge until the matching side turns on
  task dly(input integer k, input lv, output [7:0] n);
    begin
      @(negedge clk);
      while (wave[k] === lv)
        @(negedge clk);
      while (wave[k] !== lv)
        @(negedge clk);
      n = 8'h00;
      while (pout[2*k+!lv] !== 1'b1) begin
        @(negedge clk);
        n = n + 8'h01;
      end
    end
  endtask
  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 8'h00);
    rd(8'h0C, 8'h00);
    rd(8'h10, 8'h00);
    apb(1'b0, 8'h04, 8'h00);
    apb(1'b1, 8'h2C, 8'h01);
    apb(1'b1, 8'h00, 8'h0F);
    apb(1'b1, 8'h08, 8'hFF);
    rd(8'h00, 8'h00);
    rd(8'h08, 8'h00);
    apb(1'b1, 8'h2C, 8'h00);
    // start right after an update so no update falls between the
    // buffer writes and the reads that expect them still pending
    wu(1);
    dl = 8'(($random(seed) & 7) + 1);
    dh = 8'(($random(seed) & 7) + 1);
    coe <= 4'($random(seed));
    apb(1'b1, 8'h20, dl);
    apb(1'b1, 8'h24, dh);
    apb(1'b1, 8'h28, 8'hFF);
    rd(8'h10, 8'h03);
    rd(8'h18, 8'h00);
    apb(1'b1, 8'h00, 8'h0F);
    wu(1);
    rd(8'h10, 8'h00);
    rd(8'h18, dl);
    @(negedge clk);
    chk("override", 8'hFF, povr);
    for (c = 0; c < 4; c = c + 1) begin
      dly(c, 1'b1, cl);
      dly(c, 1'b0, ch);
      chk("dead time", dh - dl, ch - cl);
      chk("low dead time", {24'h00_0000, dl}, cl - 8'h02);
    end
    // common channel a: pair 3 low side must follow channel a's fall
    apb(1'b1, 8'h00, 8'h1F);
    wu(1);
    @(negedge clk);
    while (wave[0] !== 1'b1)
      @(negedge clk);
    while (wave[0] !== 1'b0)
      @(negedge clk);
    repeat (2) @(negedge clk);
    chk("common a", 8'h00, pout & 8'hC0);
    apb(1'b1, 8'h08, 8'h04);
    apb(1'b1, 8'h0C, 8'h03);
    fev <= 8'($random(seed)) & 8'hFB;
    wu(1);
    rd(8'h10, 8'h00);
    fev <= 8'h04;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("dir clear", 8'hFF, pdc);
    apb(1'b1, 8'h28, 8'h00);
    rd(8'h10, 8'h04);
    fev <= 8'h00;
    wu(2);
    @(negedge clk);
    chk("dir clear", 8'hFF, pdc);
    rd(8'h28, 8'hFF);
    apb(1'b1, 8'h10, 8'h04);
    wu(2);
    rd(8'h10, 8'h00);
    @(negedge clk);
    chk("dir clear", 8'h00, pdc);
    apb(1'b1, 8'h0C, 8'h07);
    fev <= 8'h04;
    repeat (6) @(posedge clk);
    fev <= 8'h00;
    @(negedge clk);
    chk("dir clear", 8'hFF, pdc);
    wu(2);
    rd(8'h10, 8'h04);
    @(negedge clk);
    chk("dir clear", 8'h00, pdc);
    apb(1'b1, 8'h10, 8'h00);
    rd(8'h10, 8'h04);
    apb(1'b1, 8'h0C, 8'h00);
    fev <= 8'h04;
    repeat (6) @(posedge clk);
    fev <= 8'h00;
    @(negedge clk);
    chk("dir clear", 8'h00, pdc);
    apb(1'b1, 8'h10, 8'h04);
    // unowned pairs fall back to the timer's own enables
    apb(1'b1, 8'h00, 8'h05);
    repeat (2) @(negedge clk);
    chk("override mix", {{2{coe[3]}}, 2'b11, {2{coe[1]}}, 2'b11}, povr);
    // pattern keeps pair halves apart so the overlap check still holds
    apb(1'b1, 8'h20, 8'h99);
    apb(1'b1, 8'h28, 8'h01);
    wu(1);
    apb(1'b1, 8'h00, 8'h20);
    wu(1);
    @(negedge clk);
    chk("pattern", 8'h98, pout & 8'hFE);
    chk("chan a", 8'h01, pout & 8'h01);
    repeat (16) @(negedge clk);
    chk("chan a", 8'h00, pout & 8'h01);
    chk("error flag", 32'h0000_0002, tef_n);
    test_done;
  end
endmodule
